/* File: logic/capture_compare.sv */
// Purpose: one capture/compare module of a counter array, apb slave
// Assumes: single 100 MHz clock; pin input is asynchronous
// Notes: the shared counter lives here and counts when run is set
//
// Overview of operation
// RULE1: compare enable bit turns on the comparator
// RULE2: rising only capture on rising pin edges
// RULE3: falling only capture on falling pin edges
// RULE4: both capture bits capture every pin transition
// RULE5: capture copies full 16-bit counter value
// RULE6: capture sets event flag, irq if enabled
// RULE7: flag stays until software clears it
// RULE8: later capture overwrites previous value
// RULE9: compare evaluated every clock, no missed matches
// RULE10: timer mode match sets the event flag
// RULE11: low byte write clears compare enable
// RULE12: high byte write sets compare enable
// RULE13: software writes low byte before high
// RULE14: toggle mode inverts pin on match
// RULE15: software may set or clear pin directly
// RULE16: toggle happens in hardware at the match
// RULE17: unchanged compare toggles again after wrap
// RULE18: irq gated by module and array enables
// RULE19: pwm mode drives 8-bit pulse width output
// RULE20: reserved mode bit reads fixed, ignores writes
// RULE21: pin sampled independently of other modules
// RULE22: watchdog match generates internal reset pulse
// RULE23: invalid mode combinations need no behaviour
// RULE24: edges found from synchronised successive samples
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module capture_compare (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic module_external_pin_in,
	output logic module_external_pin_out,
	output logic module_external_pin_oe,
	output logic irq,
	output logic watchdog_reset
);
	// released reset, two flops
	logic [1:0] rst_sync;
	logic rst_n;
	// apb bundle
	cc_pkg::apb_req_t req;
	logic access;
	logic wr_access;
	// registers
	cc_pkg::mode_t mode;
	logic [15:0] value;
	logic [7:0] pwm_reload;
	logic module_event_flag;
	logic [15:0] counter;
	logic run;
	logic array_irq;
	logic watchdog_select;
	// pin path
	logic [2:0] pin_sync;
	logic pin_level;
	logic pin_out;
	// events
	logic rise;
	logic fall;
	logic capture_hit;
	logic match_hit;
	logic event_set;
	logic flag_clear;

	// hold reset asserted two clocks after release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// pack bus inputs
	assign req = '{sel: psel, enable: penable, write: pwrite,
		addr: paddr, wdata: pwdata};
	// completing edge: access phase with pready sampled high; pready is
	// low for one edge after reset release, and nothing may land there
	assign access = req.sel && req.enable && pready;
	assign wr_access = access && req.write;

	// decodes a write to one register
	function automatic logic wr_hit(input logic [7:0] a,
		input logic [7:0] off);
		wr_hit = (a == off);
	endfunction : wr_hit

	// three-flop pin synchroniser; stage 0 feeds only stage 1
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync <= 3'b000;
			pin_level <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], module_external_pin_in}; // [RULE21]
			// a change counts once stages 1 and 2 agree
			if (pin_sync[1] == pin_sync[2]) begin
				pin_level <= pin_sync[2]; // [RULE24]
			end
		end
	end

	// edge detect on the filtered level via the agreed stages
	assign rise = (pin_sync[2] == pin_sync[1]) && pin_sync[2]
		&& !pin_level; // [RULE24]
	assign fall = (pin_sync[2] == pin_sync[1]) && !pin_sync[2]
		&& pin_level; // [RULE24]

	// capture qualifies only with match, toggle and pwm cleared
	always_comb begin
		capture_hit = 1'b0;
		if (!mode.match_flag_enable && !mode.toggle_enable
			&& !mode.pulse_width_enable) begin
			capture_hit = (mode.rising_capture_enable && rise) // [RULE2] [RULE4]
				|| (mode.falling_capture_enable && fall); // [RULE3] [RULE4]
		end
	end

	// comparator checked every clock, the same rate at which the running counter steps
	assign match_hit = mode.compare_enable
		&& (counter == value); // [RULE1] [RULE9]
	// match raises the event only in timer, toggle or watchdog modes
	assign event_set = capture_hit
		|| (match_hit && mode.match_flag_enable); // [RULE6] [RULE10]
	assign flag_clear = wr_access && wr_hit(req.addr, cc_pkg::off_event)
		&& req.wdata[0];

	// shared counter: runs when enabled, software may load it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			counter <= cc_pkg::value_reset;
		end else if (wr_access && wr_hit(req.addr, cc_pkg::off_counter)) begin
			counter <= req.wdata[15:0];
		end else if (run) begin
			// natural wrap lets an unchanged compare hit again
			counter <= counter + 16'h0001; // [RULE17]
		end
	end

	// control bits: run, array irq enable, watchdog select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run <= 1'b0;
			array_irq <= 1'b0;
			watchdog_select <= 1'b0;
		end else if (wr_access && wr_hit(req.addr, cc_pkg::off_ctrl)) begin
			run <= req.wdata[cc_pkg::bit_run];
			array_irq <= req.wdata[cc_pkg::bit_array_irq];
			watchdog_select <= req.wdata[cc_pkg::bit_watchdog];
		end
	end

	// mode register; value byte writes steer compare enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= cc_pkg::mode_reset;
		end else if (wr_access && wr_hit(req.addr, cc_pkg::off_mode)) begin
			// reserved bit 7 is dropped
			mode <= req.wdata[6:0]; // [RULE20] [RULE23]
		end else if (wr_access
			&& wr_hit(req.addr, cc_pkg::off_value_low)) begin
			mode.compare_enable <= 1'b0; // [RULE11]
		end else if (wr_access
			&& wr_hit(req.addr, cc_pkg::off_value_high)) begin
			mode.compare_enable <= 1'b1; // [RULE12]
		end
	end

	// compare/capture value; capture wins over a same-cycle write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value <= cc_pkg::value_reset;
		end else if (capture_hit) begin
			// whole counter copied; old value lost if unread
			value <= counter; // [RULE5] [RULE8]
		end else if (mode.pulse_width_enable && run
			&& counter[7:0] == 8'hff) begin
			// pwm duty reloads at low byte rollover, glitch free
			value[7:0] <= pwm_reload; // [RULE19]
		end else if (wr_access
			&& wr_hit(req.addr, cc_pkg::off_value_low)) begin
			value[7:0] <= req.wdata[7:0];
		end else if (wr_access
			&& wr_hit(req.addr, cc_pkg::off_value_high)) begin
			value[15:8] <= req.wdata[7:0];
		end
	end

	// pwm duty shadow follows the high byte writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_reload <= 8'h00;
		end else if (wr_access
			&& wr_hit(req.addr, cc_pkg::off_value_high)) begin
			pwm_reload <= req.wdata[7:0];
		end
	end

	// event flag: set beats clear; servicing never clears it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			module_event_flag <= 1'b0;
		end else if (event_set) begin
			module_event_flag <= 1'b1; // [RULE6]
		end else if (flag_clear) begin
			module_event_flag <= 1'b0; // [RULE7]
		end
	end

	// interrupt gated by module and array enables
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= module_event_flag && mode.event_interrupt_enable
				&& array_irq; // [RULE18]
		end
	end

	// pin output: toggle on match, pwm compare, or software write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= 1'b0;
		end else if (mode.pulse_width_enable && mode.compare_enable) begin
			// high while low byte at or above duty value
			pin_out <= (counter[7:0] >= value[7:0]); // [RULE19]
		end else if (match_hit && mode.match_flag_enable
			&& mode.toggle_enable) begin
			// inverted directly, not waiting on any service
			pin_out <= !pin_out; // [RULE14] [RULE16] [RULE17]
		end else if (wr_access && wr_hit(req.addr, cc_pkg::off_pin)) begin
			pin_out <= req.wdata[0]; // [RULE15]
		end
	end

	// pin outputs registered; driven only in output modes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			module_external_pin_out <= 1'b0;
			module_external_pin_oe <= 1'b0;
		end else begin
			module_external_pin_out <= pin_out;
			module_external_pin_oe <= mode.toggle_enable
				|| mode.pulse_width_enable;
		end
	end

	// watchdog: one-cycle reset request on each match
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_reset <= 1'b0;
		end else begin
			watchdog_reset <= watchdog_select && match_hit
				&& mode.match_flag_enable; // [RULE22]
		end
	end

	// read mux, registered; zero-wait so pready stays high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			// load in setup, and keep loading while an access still waits
			// so the word taken with pready is never stale
			if (req.sel && !(req.enable && pready)) begin
				if (req.addr == cc_pkg::off_mode) begin
					prdata <= {24'h000000, cc_pkg::reserved_read,
						mode}; // [RULE20]
				end else if (req.addr == cc_pkg::off_value_low) begin
					prdata <= {24'h000000, value[7:0]};
				end else if (req.addr == cc_pkg::off_value_high) begin
					prdata <= {24'h000000, value[15:8]};
				end else if (req.addr == cc_pkg::off_event) begin
					prdata <= {31'h0000_0000, module_event_flag};
				end else if (req.addr == cc_pkg::off_counter) begin
					prdata <= {16'h0000, counter};
				end else if (req.addr == cc_pkg::off_pin) begin
					prdata <= {31'h0000_0000, pin_out};
				end else if (req.addr == cc_pkg::off_ctrl) begin
					prdata <= {29'h0000_0000, watchdog_select,
						array_irq, run};
				end else begin
					prdata <= 32'h0000_0000;
				end
			end
		end
	end

	// a low byte write always leaves the comparator off
	property p_low_clears;
		@(posedge clk) disable iff (!rst_n)
		(wr_access && req.addr == cc_pkg::off_value_low)
			|=> !mode.compare_enable;
	endproperty
	a_low_clears: assert property (p_low_clears) // [RULE11]
		else $error("low write left compare on");

	// a high byte write always turns it on
	property p_high_sets;
		@(posedge clk) disable iff (!rst_n)
		(wr_access && req.addr == cc_pkg::off_value_high)
			|=> mode.compare_enable;
	endproperty
	a_high_sets: assert property (p_high_sets) // [RULE12]
		else $error("high write left compare off");

	// a capture loads the counter seen at the edge
	property p_capture_loads;
		@(posedge clk) disable iff (!rst_n)
		capture_hit |=> value == $past(counter);
	endproperty
	a_capture_loads: assert property (p_capture_loads) // [RULE5]
		else $error("capture value wrong");

	// any event sets the flag next cycle, even against a clear
	property p_flag_sets;
		@(posedge clk) disable iff (!rst_n)
		event_set |=> module_event_flag;
	endproperty
	a_flag_sets: assert property (p_flag_sets) // [RULE6]
		else $error("event flag not set");

	// the flag only falls after a software clear
	property p_flag_holds;
		@(posedge clk) disable iff (!rst_n)
		$fell(module_event_flag) |-> $past(flag_clear);
	endproperty
	a_flag_holds: assert property (p_flag_holds) // [RULE7]
		else $error("flag cleared without software");

	// toggle mode inverts the pin two edges after the match
	property p_toggle;
		@(posedge clk) disable iff (!rst_n)
		(match_hit && mode.match_flag_enable && mode.toggle_enable
			&& !mode.pulse_width_enable)
			|=> ##1 module_external_pin_out
			!= $past(module_external_pin_out);
	endproperty
	a_toggle: assert property (p_toggle) // [RULE14]
		else $error("pin did not toggle");

	// interrupt follows flag and both enables
	property p_irq;
		@(posedge clk) disable iff (!rst_n)
		##1 irq == $past(module_event_flag
			&& mode.event_interrupt_enable && array_irq);
	endproperty
	a_irq: assert property (p_irq) // [RULE18]
		else $error("interrupt gating wrong");

	// watchdog pulse only follows a match while selected
	property p_watchdog;
		@(posedge clk) disable iff (!rst_n)
		watchdog_reset |-> $past(watchdog_select && match_hit);
	endproperty
	a_watchdog: assert property (p_watchdog) // [RULE22]
		else $error("spurious watchdog reset");
endmodule : capture_compare

/* File: logic/cc_pkg.sv */
// Purpose: shared constants and types for the capture/compare module
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses within the block
package cc_pkg;
	// register byte offsets
	localparam logic [7:0] off_mode = 8'h00;
	localparam logic [7:0] off_value_low = 8'h04;
	localparam logic [7:0] off_value_high = 8'h08;
	localparam logic [7:0] off_event = 8'h0c;
	localparam logic [7:0] off_counter = 8'h10;
	localparam logic [7:0] off_pin = 8'h14;
	localparam logic [7:0] off_ctrl = 8'h18;
	// mode register field positions
	localparam int bit_compare_enable = 6;
	localparam int bit_rising = 5;
	localparam int bit_falling = 4;
	localparam int bit_match = 3;
	localparam int bit_toggle = 2;
	localparam int bit_pwm = 1;
	localparam int bit_irq = 0;
	// control register field positions
	localparam int bit_run = 0;
	localparam int bit_array_irq = 1;
	localparam int bit_watchdog = 2;
	// reset values
	localparam logic [6:0] mode_reset = 7'h00;
	localparam logic [15:0] value_reset = 16'h0000;
	// value read from the reserved mode bit (indeterminate by spec)
	localparam logic reserved_read = 1'b0;

	// mode register as a packed struct
	typedef struct packed {
		logic compare_enable;
		logic rising_capture_enable;
		logic falling_capture_enable;
		logic match_flag_enable;
		logic toggle_enable;
		logic pulse_width_enable;
		logic event_interrupt_enable;
	} mode_t;

	// apb request bundle
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} apb_req_t;
endpackage : cc_pkg

/* File: testbench/pin_partner.sv */
// Purpose: far-side model of the module pin
// Assumes: bench sets the level the far side would drive
// Notes: the module wins the wire whenever its enable is high
`timescale 1ns/1ps
module pin_partner (
	input wire logic drive_level,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_in
);
	// resolved wire fed back to the module input
	assign pin_in = pin_oe ? pin_out : drive_level;
endmodule : pin_partner

/* File: testbench/test_counter_array_capture_compare_module.sv */
// Purpose: self-checking apb bench for one capture/compare module
// Assumes: counter held still while capturing so values are exact
// Notes: the wrap case runs one full 16-bit counter period
`timescale 1ns/1ps
module test_counter_array_capture_compare_module;
	logic clk = 1'b0; // core clock
	logic resetn = 1'b0; // active-low reset
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pin_in, pin_out, pin_oe, irq, wd_rst;
	logic pin_drv = 1'b0; // level driven by the far side
	int n_fail = 0;
	int checked = 0;
	logic [31:0] rd; // last read data
	logic [15:0] cnt, exp_cap; // loaded counter, expected capture
	logic flag; // expected event flag
	logic [7:0] modes [3] = '{8'h21, 8'h11, 8'h31}; // rise, fall, both
	int n, k;

	// free-running clock
	always #5 clk = ~clk;

	capture_compare u_dut (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .module_external_pin_in(pin_in),
		.module_external_pin_out(pin_out),
		.module_external_pin_oe(pin_oe), .irq(irq),
		.watchdog_reset(wd_rst));
	pin_partner u_pin (.drive_level(pin_drv), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in));

	// verdict and end of run
	task conclude;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// a bound that ran out counts as a mismatch and ends the run
	task tmo(input int used, input int lim);
		if (used >= lim) begin
			n_fail++;
			conclude;
		end
	endtask : tmo

	// one apb transfer; an idle cycle follows so psel never re-asserts
	// in the time step that released it
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int t;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 40);
		rd = prdata;
		tmo(t, 40);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : xfer

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask : rdc

	// stop, load and restart the shared counter
	task run_from(input logic [15:0] c, input logic [31:0] ctl);
		wr(cc_pkg::off_ctrl, 32'h0);
		wr(cc_pkg::off_counter, {16'h0, c});
		wr(cc_pkg::off_ctrl, ctl);
	endtask : run_from

	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		rdc(cc_pkg::off_mode, 32'h0);
		rdc(cc_pkg::off_value_high, 32'h0);
		wr(8'h1c, 32'hff);
		rdc(8'h1c, 32'h0);
		chk(32'(pslverr), 32'h0);
		// capture table: every mode sees one rising and one falling edge
		exp_cap = 16'h0;
		wr(cc_pkg::off_ctrl, 32'h2);
		for (k = 0; k < 3; k++) begin
			wr(cc_pkg::off_mode, {24'h0, modes[k]});
			flag = 1'b0;
			for (n = 0; n < 2; n++) begin
				cnt = 16'h1234 + 16'(k * 256 + n * 16);
				wr(cc_pkg::off_counter, {16'h0, cnt});
				pin_drv <= ~pin_drv;
				repeat (8) @(posedge clk);
				// n is 0 for a rising edge, 1 for a falling one
				if (modes[k][5 - n]) begin
					exp_cap = cnt;
					flag = 1'b1;
				end
				rdc(cc_pkg::off_value_low, {24'h0, exp_cap[7:0]});
				rdc(cc_pkg::off_value_high, {24'h0, exp_cap[15:8]});
				rdc(cc_pkg::off_event, {31'h0, flag});
				chk(32'(irq), {31'h0, flag});
			end
			// array enable off must mask the request
			wr(cc_pkg::off_ctrl, 32'h0);
			repeat (3) @(posedge clk);
			chk(32'(irq), 32'h0);
			wr(cc_pkg::off_ctrl, 32'h2);
			wr(cc_pkg::off_event, 32'h1);
		end
		// software timer, low byte then high byte
		wr(cc_pkg::off_ctrl, 32'h0);
		wr(cc_pkg::off_mode, 32'h49);
		wr(cc_pkg::off_value_low, 32'h20);
		rdc(cc_pkg::off_mode, 32'h09);
		wr(cc_pkg::off_value_high, 32'h00);
		rdc(cc_pkg::off_mode, 32'h49);
		// the stale capture value matched the idle counter: clear it
		wr(cc_pkg::off_event, 32'h1);
		rdc(cc_pkg::off_event, 32'h0);
		run_from(16'h0010, 32'h3);
		n = 0;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		tmo(n, 100);
		// 16 counts to the compare value, flag one edge, irq one more
		chk(32'(n), 32'd18);
		// comparator off after a lone low-byte write: no match
		wr(cc_pkg::off_ctrl, 32'h0);
		wr(cc_pkg::off_event, 32'h1);
		wr(cc_pkg::off_value_low, 32'h30);
		run_from(16'h0028, 32'h3);
		repeat (40) @(posedge clk);
		rdc(cc_pkg::off_event, 32'h0);
		// fast toggle output and its wrap-around repeat
		wr(cc_pkg::off_ctrl, 32'h0);
		wr(cc_pkg::off_value_low, 32'h05);
		wr(cc_pkg::off_value_high, 32'h00);
		wr(cc_pkg::off_mode, 32'h4c);
		for (k = 0; k < 2; k++) begin
			wr(cc_pkg::off_pin, 32'(k));
			repeat (2) @(posedge clk);
			chk(32'(pin_out), 32'(k));
		end
		chk(32'(pin_oe), 32'h1);
		run_from(16'hfff0, 32'h1);
		n = 0;
		while (pin_out !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		tmo(n, 100);
		// flag left set on purpose: the pin must still toggle
		n = 0;
		while (pin_out !== 1'b1 && n < 70000) begin
			@(posedge clk);
			n++;
		end
		chk(32'(n), 32'd65536);
		// pwm: duty from the reloaded high byte
		wr(cc_pkg::off_ctrl, 32'h0);
		wr(cc_pkg::off_mode, 32'h42);
		wr(cc_pkg::off_value_high, 32'h40);
		run_from(16'h00fe, 32'h1);
		repeat (8) @(posedge clk);
		n = 0;
		for (k = 0; k < 256; k++) begin
			@(posedge clk);
			if (pin_out === 1'b1) n++;
		end
		chk(32'(n), 32'd192);
		// watchdog: one pulse for one match
		wr(cc_pkg::off_ctrl, 32'h0);
		wr(cc_pkg::off_value_low, 32'h40);
		wr(cc_pkg::off_value_high, 32'h00);
		wr(cc_pkg::off_mode, 32'h48);
		run_from(16'h0030, 32'h5);
		n = 0;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (wd_rst === 1'b1) n++;
		end
		chk(32'(n), 32'h1);
		// mid-run reset returns registers and outputs to idle
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		chk(32'(irq | wd_rst | pin_oe), 32'h0);
		rdc(cc_pkg::off_mode, 32'h0);
		rdc(cc_pkg::off_event, 32'h0);
		rdc(cc_pkg::off_ctrl, 32'h0);
		conclude;
	end
endmodule : test_counter_array_capture_compare_module
